//--- verilog/t1_tx_signalling_slot_ctrl.sv
// Transmit signalling words, per-slot control words and the slot datapath
`timescale 1ns/1ns

// Slot buffer between backplane and transmit path
module slot_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire do_push = in_valid && in_ready;
	wire do_pop = out_valid && out_ready;

	// Full when pointers differ only in the wrap bit
	assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data = mem[rd_ptr[AW-1:0]];

	// Storage has no reset; out_data shows the entry at rd_ptr even when the buffer is empty
	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= wr_ptr + (AW+1)'(do_push);
			rd_ptr <= rd_ptr + (AW+1)'(do_pop);
		end
	end
endmodule : slot_fifo

// Operation
// - Signalling words at pages 5/6, 0x10 up
// - A bit sent in frame 6
// - B bit sent in frame 12
// - C bit frame 18, ESF only
// - D bit frame 24, ESF only
// - Select bit picks serial or register signalling
// - Nibble select one uses bits 7-4
// - Nibble select zero uses bits 3-0
// - Control words at pages 7/8, 0x10 up
// - Bit 7 sends message register
// - Bit 6 inverts both directions
// - Bit 5 loops receive slot to transmit
// - Bit 4 loops transmit slot to receive
// - Bit 3 sends milliwatt or PRBS
// - Bit 2 tests serial output slot
// - Bit 0 suppresses robbed-bit signalling
module t1_tx_signalling_slot_ctrl (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Microport
	input wire logic [3:0] page,
	input wire logic [4:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	// Global controls
	input wire logic esf_mode,
	input wire logic signalling_enable,
	input wire logic nibble_select,
	input wire logic test_sequence_select,
	input wire logic [7:0] tx_message,
	// Backplane slot in: serial_data_input and serial_control_input
	input wire logic bp_valid,
	output logic bp_ready,
	input wire t1_tx_sig_pkg::bp_slot_s bp_slot,
	// Transmit line slot out
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [4:0] tx_slot,
	output logic [7:0] tx_data,
	// Receive line slot in
	input wire logic rx_valid,
	input wire t1_tx_sig_pkg::line_slot_s rx_slot,
	// Backplane slot out: serial_data_output
	output logic dout_valid,
	output logic [4:0] dout_slot,
	output logic [7:0] serial_data_output,
	// PRBS detector errors
	output logic [7:0] prbs_errors
);
	// Page/offset to channel decode, shared by read and write
	function automatic logic [5:0] map_ch(input logic [3:0] pg, input logic [4:0] ofs,
		input logic [3:0] lo, input logic [3:0] hi);
		logic [5:0] r;
		r = '0;
		if (pg == lo && ofs >= t1_tx_sig_pkg::OFS_FIRST) begin
			r = {1'b1, ofs - t1_tx_sig_pkg::OFS_FIRST};
		end else if (pg == hi && ofs >= t1_tx_sig_pkg::OFS_FIRST
			&& ofs <= t1_tx_sig_pkg::OFS_HI_LAST) begin
			r = {1'b1, ofs - t1_tx_sig_pkg::OFS_FIRST + t1_tx_sig_pkg::CH_PER_LO_PAGE};
		end
		return r;
	endfunction : map_ch

	// Advance a 2^15-1 generator by eight bits, msb first
	function automatic logic [22:0] prbs_step(input logic [14:0] s);
		logic [14:0] st;
		logic [7:0] b;
		st = s;
		b = '0;
		for (int i = 7; i >= 0; i--) begin
			b[i] = st[14] ^ st[13];
			st = {st[13:0], b[i]};
		end
		return {st, b};
	endfunction : prbs_step

	// Milliwatt sample for a phase
	function automatic logic [7:0] mw_sample(input logic [2:0] ph);
		logic [7:0] v;
		v = (ph[0] ^ ph[1]) ? t1_tx_sig_pkg::MW_1 : t1_tx_sig_pkg::MW_0;
		if (ph[2]) begin
			v = (ph[0] ^ ph[1]) ? t1_tx_sig_pkg::MW_3 : t1_tx_sig_pkg::MW_2;
		end
		return v;
	endfunction : mw_sample

	logic [3:0] sig_mem [t1_tx_sig_pkg::NUM_CH];
	logic [7:0] ctl_mem [t1_tx_sig_pkg::NUM_CH];
	logic [7:0] rx_mem [t1_tx_sig_pkg::NUM_CH];
	logic [7:0] tx_mem [t1_tx_sig_pkg::NUM_CH];
	logic [14:0] tx_prbs;
	logic [14:0] rx_prbs;
	logic [2:0] tx_mw_ph;
	logic [2:0] rx_mw_ph;

	// Register decode
	// signalling and control page maps
	wire [5:0] sig_hit = map_ch(page, addr, t1_tx_sig_pkg::PAGE_SIG_LO,
		t1_tx_sig_pkg::PAGE_SIG_HI);
	wire [5:0] ctl_hit = map_ch(page, addr, t1_tx_sig_pkg::PAGE_CTL_LO,
		t1_tx_sig_pkg::PAGE_CTL_HI);
	wire [4:0] sig_ch = sig_hit[4:0];
	wire [4:0] ctl_ch = ctl_hit[4:0];
	// anything outside the map reads zero
	wire [7:0] next_rd = sig_hit[5] ? {4'h0, sig_mem[sig_ch]} :
		ctl_hit[5] ? ctl_mem[ctl_ch] : 8'h00;

	// Register writes; unmapped offsets fall through untouched
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < t1_tx_sig_pkg::NUM_CH; i++) begin
				sig_mem[i] <= t1_tx_sig_pkg::SIG_RESET;
				ctl_mem[i] <= t1_tx_sig_pkg::CTL_RESET;
			end
		end else if (wr_en) begin
			if (sig_hit[5]) begin
				sig_mem[sig_ch] <= wr_data[3:0];
			end else if (ctl_hit[5]) begin
				ctl_mem[ctl_ch] <= wr_data;
			end
		end
	end

	// Read data held until next read
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			rd_data <= next_rd;
		end
	end

	// Backplane slots queue here so a stalled framer back-pressures the source
	logic fifo_valid;
	logic fifo_ready;
	logic [$bits(t1_tx_sig_pkg::bp_slot_s)-1:0] fifo_raw;
	t1_tx_sig_pkg::bp_slot_s cur;
	assign cur = fifo_raw;

	slot_fifo #(
		.WIDTH($bits(t1_tx_sig_pkg::bp_slot_s)),
		.DEPTH(t1_tx_sig_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(bp_valid),
		.in_ready(bp_ready),
		.in_data(bp_slot),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_raw)
	);

	// Transmit slot composition
	wire [7:0] ctl = ctl_mem[cur.slot];
	wire tx_pop = fifo_valid && fifo_ready;
	wire [22:0] tx_prbs_nx = prbs_step(tx_prbs);
	assign fifo_ready = !tx_valid || tx_ready;
	wire [7:0] src_data = ctl[t1_tx_sig_pkg::CTL_MSG] ? tx_message :
		ctl[t1_tx_sig_pkg::CTL_INV] ? ~cur.data : cur.data;
	wire [7:0] loop_data = ctl[t1_tx_sig_pkg::CTL_RLOOP] ? rx_mem[cur.slot] : src_data;
	wire [7:0] test_data = test_sequence_select ? mw_sample(tx_mw_ph) : tx_prbs_nx[7:0];
	wire tx_test = ctl[t1_tx_sig_pkg::CTL_TTEST];
	wire [7:0] body = tx_test ? test_data : loop_data;
	wire [3:0] ser_sig = nibble_select ? cur.ctrl[7:4] : cur.ctrl[3:0];
	wire [3:0] abcd = ctl[t1_tx_sig_pkg::CTL_SERSEL] ? sig_mem[cur.slot] : ser_sig;
	wire in_a = cur.frame == t1_tx_sig_pkg::FRAME_A;
	wire in_b = cur.frame == t1_tx_sig_pkg::FRAME_B;
	// C in frame 18, ESF only
	wire in_c = esf_mode && cur.frame == t1_tx_sig_pkg::FRAME_C;
	// D in frame 24, ESF only
	wire in_d = esf_mode && cur.frame == t1_tx_sig_pkg::FRAME_D;
	wire sig_bit = in_a ? abcd[t1_tx_sig_pkg::SIG_A] : in_b ? abcd[t1_tx_sig_pkg::SIG_B] :
		in_c ? abcd[t1_tx_sig_pkg::SIG_C] : abcd[t1_tx_sig_pkg::SIG_D];
	// clear channel carries no robbed bit
	wire rob = signalling_enable && !ctl[t1_tx_sig_pkg::CTL_CLEAR]
		&& (in_a || in_b || in_c || in_d);
	wire [7:0] next_tx = rob ? {body[7:1], sig_bit} : body;

	// Transmit output stage
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tx_valid <= 1'b0;
			tx_slot <= '0;
			tx_data <= 8'h00;
		end else if (fifo_ready) begin
			tx_valid <= fifo_valid;
			tx_slot <= cur.slot;
			tx_data <= next_tx;
		end
	end

	// Transmit test generators advance only when a test byte is used
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tx_prbs <= t1_tx_sig_pkg::PRBS_SEED;
			tx_mw_ph <= '0;
		end else if (tx_pop && tx_test) begin
			tx_prbs <= test_sequence_select ? tx_prbs : tx_prbs_nx[22:8];
			tx_mw_ph <= tx_mw_ph + 3'(test_sequence_select);
		end
	end

	// Slot history for the two loopbacks
	always_ff @(posedge clk_sys) begin
		if (tx_pop) begin
			tx_mem[cur.slot] <= next_tx;
		end
		if (rx_valid) begin
			rx_mem[rx_slot.slot] <= rx_slot.data;
		end
	end

	// Receive slot composition
	wire [7:0] rctl = ctl_mem[rx_slot.slot];
	wire [7:0] rx_src = rctl[t1_tx_sig_pkg::CTL_LLOOP] ? tx_mem[rx_slot.slot] : rx_slot.data;
	wire [7:0] rx_inv = rctl[t1_tx_sig_pkg::CTL_INV] ? ~rx_src : rx_src;
	wire rx_test = rctl[t1_tx_sig_pkg::CTL_RTEST];
	wire [7:0] next_dout = (rx_test && test_sequence_select) ? mw_sample(rx_mw_ph) : rx_inv;
	wire chk = rx_valid && rx_test && !test_sequence_select;

	// Serial output stage; one-cycle valid per received slot
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dout_valid <= 1'b0;
			dout_slot <= '0;
			serial_data_output <= 8'h00;
		end else begin
			dout_valid <= rx_valid;
			dout_slot <= rx_slot.slot;
			serial_data_output <= rx_valid ? next_dout : serial_data_output;
		end
	end

	// Self-synchronising PRBS check on the received channel
	logic [14:0] chk_st;
	logic [3:0] chk_err;
	always_comb begin
		chk_st = rx_prbs;
		chk_err = '0;
		for (int i = 7; i >= 0; i--) begin
			chk_err = chk_err + 4'((chk_st[14] ^ chk_st[13]) != rx_inv[i]);
			chk_st = {chk_st[13:0], rx_inv[i]};
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rx_prbs <= t1_tx_sig_pkg::PRBS_SEED;
			rx_mw_ph <= '0;
			prbs_errors <= 8'h00;
		end else begin
			if (chk) begin
				rx_prbs <= chk_st;
				prbs_errors <= (prbs_errors > 8'hff - 8'(chk_err)) ? 8'hff
					: prbs_errors + 8'(chk_err);
			end
			if (rx_valid && rx_test && test_sequence_select) begin
				rx_mw_ph <= rx_mw_ph + 3'h1;
			end
		end
	end
endmodule : t1_tx_signalling_slot_ctrl

//--- verilog/t1_tx_sig_pkg.sv
// Package: constants and carriers for the T1 signalling and slot control block
package t1_tx_sig_pkg;
	// Register pages and window
	localparam logic [3:0] PAGE_SIG_LO = 4'h5;
	localparam logic [3:0] PAGE_SIG_HI = 4'h6;
	localparam logic [3:0] PAGE_CTL_LO = 4'h7;
	localparam logic [3:0] PAGE_CTL_HI = 4'h8;
	localparam logic [4:0] OFS_FIRST = 5'h10;
	localparam logic [4:0] OFS_HI_LAST = 5'h17;
	localparam logic [4:0] CH_PER_LO_PAGE = 5'h10;
	localparam int NUM_CH = 24;
	localparam int FIFO_DEPTH = 32;
	// Signalling word bits
	localparam int SIG_A = 3;
	localparam int SIG_B = 2;
	localparam int SIG_C = 1;
	localparam int SIG_D = 0;
	// Per-slot control bits
	localparam int CTL_MSG = 7;
	localparam int CTL_INV = 6;
	localparam int CTL_RLOOP = 5;
	localparam int CTL_LLOOP = 4;
	localparam int CTL_TTEST = 3;
	localparam int CTL_RTEST = 2;
	localparam int CTL_SERSEL = 1;
	localparam int CTL_CLEAR = 0;
	// Superframe frames carrying signalling
	localparam logic [4:0] FRAME_A = 5'h06;
	localparam logic [4:0] FRAME_B = 5'h0c;
	localparam logic [4:0] FRAME_C = 5'h12;
	localparam logic [4:0] FRAME_D = 5'h18;
	// Bit position 8 of a channel byte is its lsb
	localparam int ROBBED_BIT = 0;
	// Reset values
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [3:0] SIG_RESET = 4'h0;
	localparam logic [14:0] PRBS_SEED = 15'h7fff;
	// Digital milliwatt, eight-sample mu-law cycle
	localparam logic [7:0] MW_0 = 8'h1e;
	localparam logic [7:0] MW_1 = 8'h0b;
	localparam logic [7:0] MW_2 = 8'h9e;
	localparam logic [7:0] MW_3 = 8'h8b;

	// One backplane time slot: data, control and position in superframe
	typedef struct packed {
		logic [4:0] slot;
		logic [4:0] frame;
		logic [7:0] data;
		logic [7:0] ctrl;
	} bp_slot_s;

	// One received line slot
	typedef struct packed {
		logic [4:0] slot;
		logic [7:0] data;
	} line_slot_s;
endpackage : t1_tx_sig_pkg

//--- test/t1_tx_sig_checker.sv
// Checker: port-level properties of the signalling and slot control block
`timescale 1ns/1ns
module t1_tx_sig_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port
	input wire logic [3:0] page,
	input wire logic [4:0] addr,
	input wire logic rd_en,
	input wire logic [7:0] rd_data,
	// Slot streams
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [4:0] tx_slot,
	input wire logic [7:0] tx_data,
	input wire logic rx_valid,
	input wire t1_tx_sig_pkg::line_slot_s rx_slot,
	input wire logic dout_valid,
	input wire logic [4:0] dout_slot,
	input wire logic [7:0] prbs_errors
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Register window edges and unused signalling bits read as zero
	AST_HI_UNMAPPED: assert property (
		rd_en && (page == 4'h6 || page == 4'h8) && addr > 5'h17 |=> rd_data == 8'h00)
		else $error("unmapped offset read not zero");
	AST_LOW_OFS: assert property (
		rd_en && addr < 5'h10 |=> rd_data == 8'h00) else $error("low offset read not zero");
	AST_SIG_UNUSED: assert property (
		rd_en && (page == 4'h5 || page == 4'h6) |=> rd_data[7:4] == 4'h0)
		else $error("unused signalling bits set");
	// Receive slot reaches the serial output after one cycle
	AST_DOUT_PULSE: assert property (
		rx_valid |=> dout_valid) else $error("no output for received slot");
	AST_DOUT_CAUSE: assert property (
		dout_valid |-> $past(rx_valid)) else $error("output without received slot");
	AST_DOUT_SLOT: assert property (
		rx_valid |=> dout_slot == $past(rx_slot.slot)) else $error("output slot number wrong");
	// A stalled transmit slot stays put
	AST_TX_HOLD: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_slot))
		else $error("transmit slot changed while stalled");
	AST_PRBS_MONO: assert property (
		$changed(prbs_errors) |-> prbs_errors > $past(prbs_errors))
		else $error("error count went down");
endmodule : t1_tx_sig_checker

bind t1_tx_signalling_slot_ctrl t1_tx_sig_checker i_t1_tx_sig_checker (.clk_sys, .nrst, .page,
	.addr, .rd_en, .rd_data, .tx_valid, .tx_ready, .tx_slot, .tx_data, .rx_valid, .rx_slot,
	.dout_valid, .dout_slot, .prbs_errors);

//--- test/bp_model.sv
// Backplane partner: offers data and control slots one at a time
`timescale 1ns/1ns
module bp_model (
	// Clock and mode
	input wire logic clk_sys,
	input wire logic nibble_select,
	// Slot handshake
	input wire logic bp_ready,
	output logic bp_valid,
	output t1_tx_sig_pkg::bp_slot_s bp_slot
);
	initial begin
		bp_valid = 1'b0;
		bp_slot = '0;
	end
	// Offer one slot; lines are scrambled once taken so stale data never looks valid
	task automatic send(input logic [4:0] s, f, input logic [7:0] d, input logic [3:0] n, x,
		input int gap);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		bp_valid <= 1'b1;
		bp_slot <= {s, f, d, nibble_select ? {n, x} : {x, n}};
		do @(posedge clk_sys); while (bp_ready !== 1'b1);
		bp_valid <= 1'b0;
		bp_slot <= ~bp_slot;
	endtask : send
endmodule : bp_model

//--- test/tb_top.sv
// Testbench: registers, slot streams, loopbacks and buffer fill
`timescale 1ns/1ns
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
	logic clk_sys = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rd_pend = 1'b0, hold = 1'b0;
	logic esf_mode = 1'b0, signalling_enable = 1'b0, nibble_select = 1'b0, rx_valid = 1'b0;
	logic test_sequence_select = 1'b0, tx_ready = 1'b0, bp_valid, bp_ready, tx_valid, dout_valid;
	logic [3:0] page = 4'h0;
	logic [4:0] addr = 5'h00, tx_slot, dout_slot;
	logic [7:0] wr_data = 8'h00, tx_message = 8'h00, rd_data, tx_data, serial_data_output;
	logic [7:0] prbs_errors, ctlw [24], txm [24], rxm [24], qt [$], qd [$], qr [$];
	logic [3:0] sigw [24];
	logic [15:0] rnd = 16'he983, rr = 16'he983;
	int err_count = 0, checked = 0;
	// Test sequence models: milliwatt sample count and PRBS generator states
	int mw_n = 0;
	logic [14:0] tx_ps = t1_tx_sig_pkg::PRBS_SEED, rx_ps = t1_tx_sig_pkg::PRBS_SEED;
	t1_tx_sig_pkg::bp_slot_s bp_slot;
	t1_tx_sig_pkg::line_slot_s rx_slot = '0;

	t1_tx_signalling_slot_ctrl i_t1_tx_signalling_slot_ctrl (.clk_sys, .nrst, .page, .addr,
		.wr_en, .rd_en, .wr_data, .rd_data, .esf_mode, .signalling_enable, .nibble_select,
		.test_sequence_select, .tx_message, .bp_valid, .bp_ready, .bp_slot, .tx_valid,
		.tx_ready, .tx_slot, .tx_data, .rx_valid, .rx_slot, .dout_valid, .dout_slot,
		.serial_data_output, .prbs_errors);
	bp_model i_bp_model (.clk_sys, .nibble_select, .bp_ready, .bp_valid, .bp_slot);

	always #4 clk_sys = ~clk_sys;

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr

	// Eight steps of x^15+x^14+1, msb first; the new byte is the low eight bits
	function automatic logic [14:0] prbs8(input logic [14:0] v);
		for (int i = 0; i < 8; i++) v = {v[13:0], v[14] ^ v[13]};
		return v;
	endfunction : prbs8

	// Framer side stalls at random unless holding
	always @(posedge clk_sys) begin
		rr <= lfsr(rr);
		tx_ready <= !hold && rr[1];
	end

	// Expected line byte of one slot
	function automatic logic [7:0] exp_tx(input int s, input logic [4:0] f,
		input logic [7:0] d8, input logic [3:0] n);
		logic [7:0] b;
		logic [3:0] g;
		// Remote loopback replaces the whole slot, message included
		b = ctlw[s][5] ? rxm[s] : ctlw[s][7] ? tx_message : ctlw[s][6] ? ~d8 : d8;
		g = ctlw[s][1] ? sigw[s] : n;
		if (signalling_enable && !ctlw[s][0] && (f == 5'h06 || f == 5'h0c ||
			esf_mode && (f == 5'h12 || f == 5'h18))) b[0] = g[4 - f / 6];
		return b;
	endfunction : exp_tx

	task automatic reg_op(input logic w, input logic [3:0] p, input logic [4:0] a,
		input logic [7:0] d, e);
		@(posedge clk_sys);
		wr_en <= w;
		rd_en <= !w;
		page <= p;
		addr <= a;
		wr_data <= d;
		if (!w) qr.push_back(e);
		@(posedge clk_sys);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask : reg_op

	task automatic slot(input int s, input logic [4:0] f);
		rnd = lfsr(rnd);
		// Test slots carry the test sequence; callers keep signalling off there
		if (!ctlw[s][3]) begin
			qt.push_back(exp_tx(s, f, rnd[7:0], rnd[11:8]));
		end else if (test_sequence_select) begin
			qt.push_back(mw_n[0] ? t1_tx_sig_pkg::MW_1 : t1_tx_sig_pkg::MW_0);
			mw_n++;
		end else begin
			tx_ps = prbs8(tx_ps);
			qt.push_back(tx_ps[7:0]);
		end
		i_bp_model.send(5'(s), f, rnd[7:0], rnd[11:8], rnd[15:12], rnd[0] ? 2 : 0);
	endtask : slot

	task automatic rx(input int s, input logic [7:0] m, input int d = -1);
		logic [7:0] v;
		logic [7:0] b;
		rnd = lfsr(rnd);
		v = d < 0 ? rnd[7:0] : 8'(d);
		// Loopback first, then inversion; milliwatt only when that sequence is chosen
		b = ctlw[s][4] ? txm[s] : v;
		if (ctlw[s][6]) b = ~b;
		if (ctlw[s][2] && test_sequence_select) b = m;
		@(posedge clk_sys);
		rx_valid <= 1'b1;
		rx_slot <= {5'(s), v};
		rxm[s] = v;
		qd.push_back(b);
		@(posedge clk_sys);
		rx_valid <= 1'b0;
	endtask : rx

	task automatic print_verdict();
		if (err_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	// Takes the oldest note whenever a result shows
	always @(posedge clk_sys) begin : mon
		logic [7:0] e;
		if (rd_pend) begin
			e = qr.pop_front();
			`CHK("rd_data", e, rd_data)
		end
		rd_pend = rd_en;
		if (tx_valid && tx_ready) begin
			e = qt.pop_front();
			txm[tx_slot] = e;
			`CHK("tx_data", e, tx_data)
		end
		if (dout_valid) begin
			e = qd.pop_front();
			`CHK("dout", e, serial_data_output)
		end
	end

	// Watchdog, far beyond the expected run
	initial begin
		#400000;
		err_count++;
		print_verdict();
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int k = 0; k < 2; k++) for (int s = 0; s < 24; s++) begin
			rnd = lfsr(rnd);
			if (k == 0) sigw[s] = rnd[3:0];
			if (k == 0) ctlw[s] = rnd[15:8] & 8'hc3;
			reg_op(k == 0, s < 16 ? 4'h5 : 4'h6, 5'h10 + 5'(s % 16), {rnd[7:4], sigw[s]},
				{4'h0, sigw[s]});
			reg_op(k == 0, s < 16 ? 4'h7 : 4'h8, 5'h10 + 5'(s % 16), ctlw[s], ctlw[s]);
		end
		reg_op(1'b1, 4'h6, 5'h18, 8'h5a, 8'h00);
		reg_op(1'b0, 4'h6, 5'h18, 8'h00, 8'h00);
		reg_op(1'b1, 4'h8, 5'h1f, 8'ha5, 8'h00);
		reg_op(1'b0, 4'h8, 5'h1f, 8'h00, 8'h00);
		reg_op(1'b0, 4'h7, 5'h03, 8'h00, 8'h00);
		// Every format and nibble mix with signalling enabled, and ESF with both nibbles disabled, over all signalling frames
		for (int m = 0; m < 8; m++) begin
			while (qt.size() != 0) @(posedge clk_sys);
			{esf_mode, nibble_select} <= 2'(m);
			signalling_enable <= m < 6;
			tx_message <= rnd[15:8];
			repeat (2) @(posedge clk_sys);
			for (int f = 6; f <= 30; f += 6) for (int s = 0; s < 24; s++) slot(s, 5'(f > 24 ? 1 : f));
		end
		// Fill the buffer until it refuses
		hold <= 1'b1;
		fork
			for (int i = 0; i < 40; i++) slot(i % 24, 5'h06);
		join_none
		// Up to four cycles per offered slot, 33 slots to fill buffer and output stage
		repeat (160) @(posedge clk_sys);
		`CHK("bp_ready", 1'b0, bp_ready)
		hold <= 1'b0;
		wait fork;
		while (qt.size() != 0) @(posedge clk_sys);
		// Loopbacks and milliwatt on the output side
		test_sequence_select <= 1'b1;
		reg_op(1'b1, 4'h7, 5'h13, 8'h21, 8'h00);
		reg_op(1'b1, 4'h7, 5'h14, 8'h11, 8'h00);
		reg_op(1'b1, 4'h7, 5'h15, 8'h04, 8'h00);
		ctlw[3] = 8'h21;
		ctlw[4] = 8'h11;
		ctlw[5] = 8'h04;
		for (int s = 0; s < 24; s++) rx(s, t1_tx_sig_pkg::MW_0);
		rx(5, t1_tx_sig_pkg::MW_1);
		slot(3, 5'h06);
		// Transmit test slot, clear channel: milliwatt, then PRBS after the select drops
		reg_op(1'b1, 4'h7, 5'h16, 8'h09, 8'h00);
		ctlw[6] = 8'h09;
		slot(6, 5'h01);
		slot(6, 5'h01);
		while (qt.size() != 0) @(posedge clk_sys);
		test_sequence_select <= 1'b0;
		@(posedge clk_sys);
		slot(6, 5'h01);
		slot(6, 5'h01);
		// Received PRBS on slot 5: clean bytes, then one flipped bit costs three errors
		for (int i = 0; i < 6; i++) begin
			rx_ps = prbs8(rx_ps);
			rx(5, 8'h00, int'(rx_ps[7:0] ^ (i == 3 ? 8'h80 : 8'h00)));
			if (i == 2) begin
				repeat (2) @(posedge clk_sys);
				`CHK("prbs_errors", 8'h00, prbs_errors)
			end
		end
		repeat (2) @(posedge clk_sys);
		`CHK("prbs_errors", 8'h03, prbs_errors)
		while (qt.size() != 0) @(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
		print_verdict();
	end
endmodule : tb_top
